// file: rtl/pi_to_p_mode_switch.sv
// Notes on behaviour
// - accel over its level forces P control
// - error pulses over level force P control
// - position variant: bit B set disables switch
// - speed variant: D,C pick torque/speed/accel/off
// - position variant: D,C 11 picks error pulses
// - torque level in percent, reset 200
// - speed level in r/min, reset 0
// - accel level 0..3000, reset 0
// - error level 0..10000, reset 10000
// - speed variant: error level is zero clamp
// - speed variant phase compensation, constant 0..100
// - gain follows constant; zero means none
// - torque reference over level forces P control
// - speed reference over level forces P
`timescale 1ns/10ps
`default_nettype none
`include "mode_switch_map.svh"

module pi_to_p_mode_switch
    import mode_switch_pkg::*;
#(
    parameter logic [15:0] TRQ_MAX_PCT = 16'h012c,
    parameter logic [15:0] SPD_MAX_RPM = 16'h1388
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic position_variant,
    input wire logic cfg_load,
    input wire logic [15:0] mode_select_word,
    input wire trip_cfg_t trip_cfg_in,
    input wire loop_qty_t loop_qty,
    input wire logic signed [15:0] speed_fb,
    output logic p_control,
    output det_sel_t det_active,
    output logic [15:0] mode_word_held,
    output trip_cfg_t trip_cfg_held,
    output logic [13:0] zero_clamp_level,
    output logic zero_clamp_valid,
    output logic signed [23:0] comp_term,
    output logic cyc_pulse
);

    localparam logic [7:0] CYC_LAST = 8'(`CTRL_CYCLES - 1);

    logic [7:0] cyc_cnt_q;
    logic cyc_en;
    logic [15:0] mode_q;
    trip_cfg_t cfg_q;
    trip_cfg_t cfg_d;
    det_sel_t det_w;
    loop_law_t law_q;
    loop_law_t law_d;
    logic [23:0] mag [4];
    logic [23:0] thr [4];
    logic [3:0] exceed;
    logic sel_exceed;

    // pick detection quantity from the held word
    function automatic det_sel_t decode_det(input logic [15:0] w, input logic pos);
        logic [1:0] dc;
        dc = {w[`MS_BIT_D], w[`MS_BIT_C]};
        if (pos && w[`MS_BIT_B]) begin
            decode_det = DET_OFF;
        end else if (dc == 2'b11) begin
            decode_det = pos ? DET_ERROR : DET_OFF;
        end else begin
            decode_det = det_sel_t'({1'b0, dc});
        end
    endfunction

    // magnitude with the most negative code saturated instead of wrapping
    function automatic logic [23:0] magnitude(input logic signed [23:0] x);
        if (x == 24'sh800000) begin
            magnitude = 24'h7fffff;
        end else if (x < 0) begin
            magnitude = 24'(-x);
        end else begin
            magnitude = 24'(x);
        end
    endfunction

    // clamp a 16-bit level to its settable top
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] top);
        clamp16 = (v > top) ? top : v;
    endfunction

    // control cycle divider; all detection runs on this one-cycle enable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_cnt_q <= 8'h00;
        end else if (cyc_cnt_q == CYC_LAST) begin
            cyc_cnt_q <= 8'h00;
        end else begin
            cyc_cnt_q <= cyc_cnt_q + 8'h01;
        end
    end

    assign cyc_en = (cyc_cnt_q == CYC_LAST);

    // out-of-range writes are clamped rather than refused, so a bad value can't disable the loop
    always_comb begin
        cfg_d = trip_cfg_in;
        cfg_d.torque_trip_level = clamp16(trip_cfg_in.torque_trip_level, TRQ_MAX_PCT);
        cfg_d.speed_trip_level = clamp16(trip_cfg_in.speed_trip_level, SPD_MAX_RPM);
        if (trip_cfg_in.accel_trip_level > `ACC_TRIP_MAX) begin
            cfg_d.accel_trip_level = `ACC_TRIP_MAX;
        end
        if (trip_cfg_in.error_trip_level > `ERR_TRIP_MAX) begin
            cfg_d.error_trip_level = `ERR_TRIP_MAX;
        end
        if (trip_cfg_in.phase_comp_constant > `COMP_MAX) begin
            cfg_d.phase_comp_constant = `COMP_MAX;
        end
    end

    // held constants start at their factory values
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q.torque_trip_level <= `TRQ_TRIP_RESET;
            cfg_q.speed_trip_level <= `SPD_TRIP_RESET;
            cfg_q.accel_trip_level <= `ACC_TRIP_RESET;
            cfg_q.error_trip_level <= `ERR_TRIP_RESET;
            cfg_q.phase_comp_constant <= `COMP_RESET;
        end else if (cfg_load) begin
            cfg_q <= cfg_d;
        end
    end

    // mode select word, all bits clear after reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `MS_RESET;
        end else if (cfg_load) begin
            mode_q <= mode_select_word;
        end
    end

    assign det_w = decode_det(mode_q, position_variant);

    // magnitudes of sign-extended quantities and zero-extended thresholds, in detection-code order
    assign mag[0] = magnitude(24'(loop_qty.torque_ref));
    assign mag[1] = magnitude(24'(loop_qty.speed_ref));
    assign mag[2] = magnitude(24'(loop_qty.accel));
    assign mag[3] = magnitude(loop_qty.error_pulse);
    assign thr[0] = {8'h00, cfg_q.torque_trip_level};
    assign thr[1] = {8'h00, cfg_q.speed_trip_level};
    assign thr[2] = {12'h000, cfg_q.accel_trip_level};
    assign thr[3] = {10'h000, cfg_q.error_trip_level};

    // one symmetric compare per quantity; equal to the level still counts as PI
    for (genvar i = 0; i < 4; i++) begin : g_cmp
        assign exceed[i] = mag[i] > thr[i];
    end

    assign sel_exceed = (det_w == DET_OFF) ? 1'b0 : exceed[det_w[1:0]];

    // next control law
    always_comb begin
        law_d = law_q;
        if (det_w == DET_OFF) begin
            law_d = LAW_PI;
        end else if (cyc_en) begin
            law_d = sel_exceed ? LAW_P : LAW_PI;
        end
    end

    // disabling takes effect at once, not at the next control cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            law_q <= LAW_PI;
        end else begin
            unique case (law_d)
                LAW_PI: law_q <= LAW_PI;
                LAW_P: law_q <= LAW_P;
            endcase
        end
    end

    // compensation only exists in the speed/torque variant
    phase_comp_gain u_comp (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cyc_en(cyc_en),
        .comp_enable(!position_variant),
        .phase_comp_constant(cfg_q.phase_comp_constant),
        .speed_fb(speed_fb),
        .comp_term(comp_term)
    );

    // status outputs
    assign p_control = (law_q == LAW_P);
    assign det_active = det_w;
    assign mode_word_held = mode_q;
    assign trip_cfg_held = cfg_q;
    assign zero_clamp_level = cfg_q.error_trip_level;
    assign zero_clamp_valid = !position_variant;
    assign cyc_pulse = cyc_en;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_accel_trip;
        cyc_en && det_w == DET_ACCEL && mag[2] > thr[2] |=> p_control;
    endproperty
    a_accel_trip: assert property (p_accel_trip) else $error("accel over level did not select P");

    property p_error_trip;
        cyc_en && det_w == DET_ERROR && mag[3] > thr[3] |=> p_control;
    endproperty
    a_error_trip: assert property (p_error_trip) else $error("error over level did not select P");

    property p_b_disable;
        position_variant && mode_q[`MS_BIT_B] |-> det_w == DET_OFF ##1 !p_control;
    endproperty
    a_b_disable: assert property (p_b_disable) else $error("bit B did not disable switch");

    property p_speed_off;
        !position_variant && mode_q[`MS_BIT_D] && mode_q[`MS_BIT_C] |-> det_w == DET_OFF;
    endproperty
    a_speed_off: assert property (p_speed_off) else $error("code 11 not off in speed variant");

    property p_pos_error;
        position_variant && !mode_q[`MS_BIT_B] && mode_q[`MS_BIT_D] && mode_q[`MS_BIT_C]
            |-> det_w == DET_ERROR;
    endproperty
    a_pos_error: assert property (p_pos_error) else $error("code 11 not error in position");

    property p_torque_trip;
        cyc_en && det_w == DET_TORQUE && mag[0] > thr[0] |=> p_control;
    endproperty
    a_torque_trip: assert property (p_torque_trip) else $error("torque over level did not select P");

    property p_speed_trip;
        cyc_en && det_w == DET_SPEED && mag[1] > thr[1] |=> p_control;
    endproperty
    a_speed_trip: assert property (p_speed_trip) else $error("speed over level did not select P");

    property p_back_to_pi;
        cyc_en && !sel_exceed |=> !p_control;
    endproperty
    a_back_to_pi: assert property (p_back_to_pi) else $error("did not return to PI");

    property p_hold_between;
        !cyc_en && det_w != DET_OFF && $stable(det_w) |=> $stable(p_control);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("law changed off cycle");

    property p_limits;
        cfg_load |=> cfg_q.accel_trip_level <= `ACC_TRIP_MAX && cfg_q.error_trip_level <= `ERR_TRIP_MAX;
    endproperty
    a_limits: assert property (p_limits) else $error("level above settable range");

    property p_comp_zero;
        cyc_en && (cfg_q.phase_comp_constant == 7'h00 || position_variant) |=> comp_term == 24'sh000000;
    endproperty
    a_comp_zero: assert property (p_comp_zero) else $error("compensation with zero constant");

    property p_comp_max;
        cfg_q.phase_comp_constant <= `COMP_MAX;
    endproperty
    a_comp_max: assert property (p_comp_max) else $error("compensation constant above 100");

    property p_cyc_spacing;
        cyc_en |=> !cyc_en [*3];
    endproperty
    a_cyc_spacing: assert property (p_cyc_spacing) else $error("control cycle pulse too dense");

    c_torque_p: cover property (det_w == DET_TORQUE && $rose(p_control));
    c_accel_p: cover property (det_w == DET_ACCEL && $rose(p_control));
    c_error_p: cover property (det_w == DET_ERROR && $rose(p_control));
    c_comp_on: cover property (comp_term != 24'sh000000);

endmodule // pi_to_p_mode_switch
`default_nettype wire

// file: common/mode_switch_map.svh
`ifndef MODE_SWITCH_MAP_SVH
`define MODE_SWITCH_MAP_SVH

// mode select word: bit positions of the enable and selection digits
`define MS_BIT_B 11
`define MS_BIT_C 12
`define MS_BIT_D 13
`define MS_RESET 16'h0000

// reset (factory) values of the held constants
`define TRQ_TRIP_RESET 16'h00c8
`define SPD_TRIP_RESET 16'h0000
`define ACC_TRIP_RESET 12'h000
`define ERR_TRIP_RESET 14'h2710
`define COMP_RESET 7'h00

// settable upper limits
`define ACC_TRIP_MAX 12'hbb8
`define ERR_TRIP_MAX 14'h2710
`define COMP_MAX 7'h64

// compensation gain is constant / 2**COMP_SHIFT
`define COMP_SHIFT 6

// control cycle timing, clock period 5 ns
`define CLK_PERIOD_PS 5000
`define CTRL_CYCLE_NS 1000
`define CTRL_CYCLES ((`CTRL_CYCLE_NS * 1000) / `CLK_PERIOD_PS)

`endif

// file: common/mode_switch_pkg.sv
`default_nettype none
package mode_switch_pkg;

    // detection quantity picked by the mode select word
    typedef enum logic [2:0] {
        DET_TORQUE = 3'b000,
        DET_SPEED = 3'b001,
        DET_ACCEL = 3'b010,
        DET_ERROR = 3'b011,
        DET_OFF = 3'b100
    } det_sel_t;

    // speed loop control law
    typedef enum logic [0:0] {
        LAW_PI = 1'b0,
        LAW_P = 1'b1
    } loop_law_t;

    // constants loaded together from the configuring party
    typedef struct packed {
        logic [15:0] torque_trip_level;
        logic [15:0] speed_trip_level;
        logic [11:0] accel_trip_level;
        logic [13:0] error_trip_level;
        logic [6:0] phase_comp_constant;
    } trip_cfg_t;

    // live loop quantities, sampled once per control cycle
    typedef struct packed {
        logic signed [15:0] torque_ref;
        logic signed [15:0] speed_ref;
        logic signed [15:0] accel;
        logic signed [23:0] error_pulse;
    } loop_qty_t;

endpackage
`default_nettype wire

// file: rtl/phase_comp_gain.sv
`timescale 1ns/10ps
`default_nettype none
`include "mode_switch_map.svh"

module phase_comp_gain
    import mode_switch_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cyc_en,
    input wire logic comp_enable,
    input wire logic [6:0] phase_comp_constant,
    input wire logic signed [15:0] speed_fb,
    output logic signed [23:0] comp_term
);

    logic signed [15:0] prev_fb_q;
    logic signed [16:0] delta;
    logic signed [24:0] product;
    logic signed [24:0] scaled;
    logic signed [23:0] comp_term_d;

    // feedback step per control cycle stands in for the detection phase lag
    assign delta = 17'(speed_fb) - 17'(prev_fb_q);
    assign product = 25'(delta) * $signed({18'h00000, phase_comp_constant});
    assign scaled = product >>> `COMP_SHIFT;
    // gain scales linearly with the constant; zero gives no term at all
    assign comp_term_d = (comp_enable && phase_comp_constant != 7'h00) ? scaled[23:0] : 24'sh000000;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_fb_q <= 16'sh0000;
        end else if (cyc_en) begin
            prev_fb_q <= speed_fb;
        end
    end

    // registered so the term is steady for a whole control cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            comp_term <= 24'sh000000;
        end else if (cyc_en) begin
            comp_term <= comp_term_d;
        end
    end

endmodule // phase_comp_gain
`default_nettype wire

// file: dv/host_ref_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_ref_model
    import mode_switch_pkg::*;
(
    input wire logic ref_clk,
    input wire logic cyc_pulse,
    input wire loop_qty_t qty_cmd,
    input wire logic signed [15:0] fb_cmd,
    output loop_qty_t loop_qty,
    output logic signed [15:0] speed_fb
);
    // host moves its references on falling edges only, never in a pulse cycle,
    // so the block never samples a half-updated set of references
    always @(negedge ref_clk) begin
        if (cyc_pulse !== 1'b1) begin
            loop_qty <= qty_cmd;
            speed_fb <= fb_cmd;
        end
    end
endmodule // host_ref_model

`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "mode_switch_map.svh"

module tb
    import mode_switch_pkg::*;
;
    localparam logic [15:0] TRQ_MAX = 16'h012c;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic position_variant = 1'b1;
    logic cfg_load = 1'b0;
    logic [15:0] mode_select_word = 16'h0000;
    trip_cfg_t trip_cfg_in = '0;
    loop_qty_t qty_cmd = '0;
    logic signed [15:0] fb_cmd = 16'sh0000;
    loop_qty_t loop_qty;
    logic signed [15:0] speed_fb;
    logic p_control;
    det_sel_t det_active;
    logic [15:0] mode_word_held;
    trip_cfg_t trip_cfg_held;
    logic [13:0] zero_clamp_level;
    logic zero_clamp_valid;
    logic signed [23:0] comp_term;
    logic cyc_pulse;
    int miscompares = 0;
    int checks_done = 0;

    always #2.5 ref_clk = ~ref_clk;

    pi_to_p_mode_switch #(.TRQ_MAX_PCT(TRQ_MAX), .SPD_MAX_RPM(16'h1388)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .position_variant(position_variant),
        .cfg_load(cfg_load), .mode_select_word(mode_select_word), .trip_cfg_in(trip_cfg_in),
        .loop_qty(loop_qty), .speed_fb(speed_fb), .p_control(p_control), .det_active(det_active),
        .mode_word_held(mode_word_held), .trip_cfg_held(trip_cfg_held),
        .zero_clamp_level(zero_clamp_level), .zero_clamp_valid(zero_clamp_valid),
        .comp_term(comp_term), .cyc_pulse(cyc_pulse));

    host_ref_model host_u (.ref_clk(ref_clk), .cyc_pulse(cyc_pulse), .qty_cmd(qty_cmd),
        .fb_cmd(fb_cmd), .loop_qty(loop_qty), .speed_fb(speed_fb));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // wide enough for the whole held-constant struct, so no field escapes the compare
    task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // reset spans two clocks; the variant only changes while reset is held
    task automatic do_reset(input logic v);
        @(negedge ref_clk);
        reset_n = 1'b0;
        position_variant = v;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
    endtask

    // one-cycle load strobe; held values are settled at the following falling edge
    task automatic load(input logic [2:0] dcb, input trip_cfg_t c);
        @(negedge ref_clk);
        mode_select_word = {2'b00, dcb, 11'h000};
        trip_cfg_in = c;
        cfg_load = 1'b1;
        @(negedge ref_clk);
        cfg_load = 1'b0;
    endtask

    // hand references to the host, then wait out one control cycle and its answer
    task automatic cycle(input loop_qty_t q, input logic signed [15:0] fb);
        int n;
        qty_cmd <= q;
        fb_cmd <= fb;
        repeat (2) @(negedge ref_clk);
        n = 0;
        while (cyc_pulse !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk("pulse spacing", n <= 200, 1);
        repeat (2) @(negedge ref_clk);
    endtask

    function automatic loop_qty_t mk(input int k, input int v);
        loop_qty_t q;
        q = '0;
        case (k)
            0: q.torque_ref = v[15:0];
            1: q.speed_ref = v[15:0];
            2: q.accel = v[15:0];
            default: q.error_pulse = v[23:0];
        endcase
        return q;
    endfunction

    function automatic det_sel_t exp_det(input logic v, input logic [2:0] dcb);
        if ((v && dcb[0]) || (!v && dcb[2:1] == 2'b11)) begin
            return DET_OFF;
        end
        return det_sel_t'({1'b0, dcb[2:1]});
    endfunction

    // watchdog: the full sequence needs about 22 us
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    initial begin
        int k;
        int j;
        int v;
        int lv[4];
        int fbv;
        trip_cfg_t c;
        lv = '{150, 1000, 3000, 10000};
        c = {`TRQ_TRIP_RESET, `SPD_TRIP_RESET, `ACC_TRIP_RESET, `ERR_TRIP_RESET, `COMP_RESET};
        trip_cfg_in = c;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        chk("reset constants", trip_cfg_held, c);
        chk("reset word", mode_word_held, 16'h0000);
        chk("reset det", det_active, DET_TORQUE);
        chk("clamp valid pos", zero_clamp_valid, 1'b0);
        // position variant: every B,C,D combination
        for (k = 0; k < 8; k++) begin
            load(k[2:0], c);
            chk("det pos", det_active, exp_det(1'b1, k[2:0]));
            chk("word held", mode_word_held, {2'b00, k[2:0], 11'h000});
        end
        // accel and error levels at the top of their ranges, torque and speed below; magnitudes tried at the level and one above it, both signs
        c = {16'h0096, 16'h03e8, 12'hbb8, 14'h2710, 7'h00};
        for (k = 0; k < 4; k++) begin
            load({k[1:0], 1'b0}, c);
            for (j = 0; j < 4; j++) begin
                v = (j == 0) ? lv[k] : (j == 1) ? lv[k] + 1 : (j == 2) ? -lv[k] - 1 : -lv[k];
                cycle(mk(k, v), 16'sh0000);
                chk("p_control", p_control, j == 1 || j == 2);
            end
        end
        // bit B set mid-trip drops P without waiting for a pulse
        cycle(mk(3, 10001), 16'sh0000);
        chk("p before off", p_control, 1);
        load(3'b111, c);
        @(negedge ref_clk);
        chk("p after off", p_control, 0);
        // compensation stays out in the position variant
        c.phase_comp_constant = 7'h40;
        load(3'b000, c);
        cycle(mk(0, 0), 16'sh0100);
        chk("comp pos", comp_term, 24'sh000000);
        do_reset(1'b0);
        chk("clamp valid", zero_clamp_valid, 1);
        chk("clamp level", zero_clamp_level, `ERR_TRIP_RESET);
        for (k = 0; k < 8; k += 2) begin
            load(k[2:0], c);
            chk("det spd", det_active, exp_det(1'b0, k[2:0]));
        end
        // loads above every limit are clamped
        load(3'b000, {16'h0200, 16'hffff, 12'hfa0, 14'h2ee0, 7'h78});
        chk("clamped", trip_cfg_held, {TRQ_MAX, 16'h1388, `ACC_TRIP_MAX, `ERR_TRIP_MAX, `COMP_MAX});
        chk("clamp level", zero_clamp_level, `ERR_TRIP_MAX);
        // tuning starts at zero and the constant is raised step by step
        c.phase_comp_constant = 7'h00;
        load(3'b000, c);
        fbv = 0;
        cycle(mk(0, 0), 16'sh0000);
        for (k = 0; k < 3; k++) begin
            c.phase_comp_constant = 7'(32 * k);
            load(3'b000, c);
            fbv = (k == 2) ? fbv - 128 : fbv + 128;
            cycle(mk(0, 0), fbv[15:0]);
            chk("comp term", comp_term, (k == 2) ? -24'sd128 : 24'(64 * k));
        end
        complete_run();
    end
endmodule // tb

`default_nettype wire
